// File: rtsq_pkg.sv
/*
  rtsq_pkg: constants shared by the tag transmit sequencer.
  Assumes a single 100 MHz on-board oscillator clock, free running
  and unrelated to the reader carrier.
*/
package rtsq_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_PER_US = 1000 / CLK_PERIOD_NS;

  // manchester half bit, 7 us, two halves make one 14 us bit
  localparam int unsigned HALF_BIT_NS = 7000;
  localparam int unsigned HALF_BIT_CYC_INT = HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W = 10;
  localparam logic [DIV_W-1:0] HALF_BIT_LAST =
    DIV_W'(HALF_BIT_CYC_INT - 1);

  // frame
  localparam int unsigned FRAME_BITS = 154;
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] FIRST_IDX = 8'h00;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_BITS - 1);

  // sleep, nominal 100 ms
  localparam int unsigned SLEEP_MS = 100;
  localparam int unsigned SLEEP_CYC_NOM = SLEEP_MS * 1000 * CLK_PER_US;
  localparam int unsigned SLP_W = 24;

  // two-entry buffer
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_CNT_W = 2;
  localparam logic [BUF_CNT_W-1:0] BUF_FULL = BUF_CNT_W'(BUF_DEPTH);
  localparam logic [BUF_CNT_W-1:0] BUF_EMPTY = 2'h0;

  // gate levels
  localparam logic GATE_CLOAK = 1'b1;

  typedef enum logic [2:0] {
    ST_LOAD  = 3'h1,
    ST_SEND  = 3'h2,
    ST_SLEEP = 3'h4
  } rtsq_state_type;

endpackage : rtsq_pkg

// File: rtsq_sequencer.sv
/*
  rtsq_sequencer: reads the 154-bit code word serially, passes it
  through a two-entry buffer, manchester-encodes it onto the
  modulation gate, then holds the gate on (cloaked) for the sleep time
  and starts over. Assumes code_word is static and in the clk domain.
*/
// Functional notes
// RL1 - bit rate 70 kHz from own clock
// RL2 - timing independent of reader carrier
// RL3 - every sent bit is manchester coded
// RL4 - frame is all 154 bits back to back
// RL5 - sleep about 100 ms after last bit
// RL6 - gate on when modulation high
// RL7 - gate off when modulation low
// RL8 - gate held on throughout sleep
// RL9 - frames and sleeps alternate while powered
// RL10 - reader decodes high envelope as cloaked
// RL11 - one low-high, zero high-low, 7 us halves
// RL12 - bits read serially from the array
// RL13 - each frame starts at bit zero, in order
`timescale 1ns/100ps
module rtsq_sequencer
  import rtsq_pkg::*;
#(
  parameter int unsigned SLEEP_CYC = SLEEP_CYC_NOM,
  parameter int unsigned HALF_CYC = HALF_BIT_CYC_INT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [FRAME_BITS-1:0] code_word,
  output logic mod_gate,
  output logic sleeping
);

  localparam logic [SLP_W-1:0] SLEEP_LAST = SLP_W'(SLEEP_CYC - 1);
  // half-bit length, default 7 us; a bench may shorten it
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);

  rtsq_state_type state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [SLP_W-1:0] slp_reg;
  logic [IDX_W-1:0] rd_idx_reg;
  logic rd_act_reg;
  logic [IDX_W-1:0] sent_reg;
  logic half_reg;
  logic cur_bit_reg;
  logic gate_reg;
  logic [BUF_DEPTH-1:0] buf_mem_reg;
  logic buf_wr_reg;
  logic buf_rd_reg;
  logic [BUF_CNT_W-1:0] buf_cnt_reg;

  logic half_tick;
  logic sleep_done;
  logic in_valid;
  logic in_ready;
  logic in_bit;
  logic out_valid;
  logic out_ready;
  logic out_bit;
  logic push;
  logic pop;
  logic last_bit;

  // first half carries the inverse, second half the bit itself
  function automatic logic manch_level(input logic bit_val,
                                       input logic second_half);
    manch_level = second_half ? bit_val : ~bit_val;
  endfunction : manch_level

  // half-bit enable from the local oscillator only
  assign half_tick = (state_reg == ST_SEND) &&
                     (div_reg == HALF_LAST); // RL1 RL2
  assign sleep_done = (state_reg == ST_SLEEP) && (slp_reg == SLEEP_LAST);
  assign last_bit = (sent_reg == LAST_IDX);

  // serial array reader
  assign in_valid = rd_act_reg;
  assign in_bit = code_word[rd_idx_reg]; // RL12
  assign push = in_valid && in_ready;

  // two-entry buffer
  assign in_ready = (buf_cnt_reg != BUF_FULL);
  assign out_valid = (buf_cnt_reg != BUF_EMPTY);
  assign out_bit = buf_mem_reg[buf_rd_reg];
  assign pop = out_valid && out_ready;
  assign out_ready = ((state_reg == ST_LOAD) ||
                      (half_tick && half_reg && !last_bit));

  assign mod_gate = gate_reg;
  assign sleeping = (state_reg == ST_SLEEP);

  // reader: restart at bit zero on power-up and on every wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_idx_reg <= FIRST_IDX;
      rd_act_reg <= 1'b1;
    end else if (sleep_done) begin
      rd_idx_reg <= FIRST_IDX; // RL13
      rd_act_reg <= 1'b1;
    end else if (push) begin
      if (rd_idx_reg == LAST_IDX) begin
        rd_act_reg <= 1'b0;
      end else begin
        rd_idx_reg <= rd_idx_reg + 8'h01; // RL13
      end
    end
  end

  // buffer storage and pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_mem_reg <= '0;
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= BUF_EMPTY;
    end else begin
      if (push) begin
        buf_mem_reg[buf_wr_reg] <= in_bit;
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (pop) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      if (push && !pop) begin
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      end else if (pop && !push) begin
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
      end
    end
  end

  // half-bit divider, restarted at each frame start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
    end else if (state_reg != ST_SEND || half_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 10'h001;
    end
  end

  // sleep timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slp_reg <= '0;
    end else if (state_reg != ST_SLEEP || sleep_done) begin
      slp_reg <= '0;
    end else begin
      slp_reg <= slp_reg + 24'h000001; // RL5
    end
  end

  // sequencer and encoder
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_LOAD;
      sent_reg <= FIRST_IDX;
      half_reg <= 1'b0;
      cur_bit_reg <= 1'b0;
      gate_reg <= GATE_CLOAK;
    end else begin
      unique case (state_reg)
        ST_LOAD: begin
          gate_reg <= GATE_CLOAK;
          if (pop) begin
            state_reg <= ST_SEND;
            sent_reg <= FIRST_IDX;
            half_reg <= 1'b0;
            cur_bit_reg <= out_bit;
            gate_reg <= manch_level(out_bit, 1'b0); // RL3 RL6 RL7 RL11
          end
        end
        ST_SEND: begin
          if (half_tick && !half_reg) begin
            half_reg <= 1'b1;
            gate_reg <= manch_level(cur_bit_reg, 1'b1); // RL3 RL6 RL7 RL11
          end else if (half_tick && last_bit) begin
            state_reg <= ST_SLEEP; // RL4 RL5
            gate_reg <= GATE_CLOAK; // RL8
          end else if (half_tick) begin
            sent_reg <= sent_reg + 8'h01; // RL4
            half_reg <= 1'b0;
            cur_bit_reg <= out_bit;
            gate_reg <= manch_level(out_bit, 1'b0); // RL3 RL11
          end
        end
        ST_SLEEP: begin
          gate_reg <= GATE_CLOAK; // RL8
          if (sleep_done) begin
            state_reg <= ST_LOAD; // RL9
          end
        end
      endcase
    end
  end

  // cycles since the last half boundary, checked below
  logic [DIV_W-1:0] seg_cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seg_cnt_reg <= '0;
    end else if (state_reg != ST_SEND || half_tick) begin
      seg_cnt_reg <= '0;
    end else begin
      seg_cnt_reg <= seg_cnt_reg + 10'h001;
    end
  end

  a_half_period: assert property ( // RL1
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SEND && $changed(gate_reg) && $past(state_reg) ==
      ST_SEND) |-> $past(seg_cnt_reg) == HALF_LAST)
    else $error("half bit length wrong");

  a_manch_first: assert property ( // RL3
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SEND && !half_reg) |-> gate_reg == ~cur_bit_reg)
    else $error("first half level wrong");

  a_manch_second: assert property ( // RL11
    @(posedge clk) disable iff (rst)
    (half_tick && !half_reg) |=> gate_reg == cur_bit_reg && half_reg)
    else $error("second half level wrong");

  a_frame_len: assert property ( // RL4
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SEND ##1 state_reg == ST_SLEEP) |->
      $past(sent_reg) == LAST_IDX)
    else $error("frame not 154 bits");

  a_sleep_cloaked: assert property ( // RL8
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SLEEP) |-> mod_gate && sleeping)
    else $error("gate off during sleep");

  a_sleep_length: assert property ( // RL5
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SLEEP ##1 state_reg == ST_LOAD) |->
      $past(slp_reg) == SLEEP_LAST)
    else $error("sleep length wrong");

  a_wake_resend: assert property ( // RL9
    @(posedge clk) disable iff (rst)
    sleep_done |=> state_reg == ST_LOAD ##[1:4] state_reg == ST_SEND)
    else $error("no frame after wake");

  a_first_bit: assert property ( // RL13
    @(posedge clk) disable iff (rst)
    (state_reg == ST_LOAD && pop) |-> out_bit == code_word[0])
    else $error("frame not started at bit zero");

  a_read_serial: assert property ( // RL12
    @(posedge clk) disable iff (rst)
    (push && rd_idx_reg != LAST_IDX) |=> rd_idx_reg == $past(rd_idx_reg)
      + 8'h01)
    else $error("array not read in order");

  a_buf_bound: assert property (
    @(posedge clk) disable iff (rst)
    buf_cnt_reg <= BUF_FULL && !(pop && !out_valid))
    else $error("buffer overflow or underflow");

endmodule : rtsq_sequencer

// File: rtsq_reader_model.sv
/*
  rtsq_reader_model: reader side of the tag link, seen as the voltage
  envelope of the reader coil. Assumes mod_gate is the tag's gate level.
*/
`timescale 1ns/100ps
module rtsq_reader_model (
  input wire logic mod_gate,
  output logic env_high
);
  // detuned tag loads the coil less, so the envelope rises
  // no carrier lock is assumed, the envelope follows the gate alone
  always_comb begin
    env_high = mod_gate;
  end
endmodule : rtsq_reader_model

// File: rtsq_sequencer_tb_top.sv
/*
  rtsq_sequencer_tb_top: self-checking bench for the tag transmit
  sequencer. Assumes a 100 MHz clock and shortened sleep and half-bit
  parameters, so a full frame fits a short run.
*/
`timescale 1ns/100ps
module rtsq_sequencer_tb_top
  import rtsq_pkg::*;
;
  localparam int unsigned SLP = 50;
  localparam int unsigned HALF = 100;
  localparam int unsigned BIT_CYC = 2 * HALF;
  localparam logic [FRAME_BITS-1:0] PAT_A = {77{2'h2}};
  localparam logic [FRAME_BITS-1:0] PAT_B = {22{7'h4b}};
  logic clk;
  logic rst;
  logic [FRAME_BITS-1:0] code_word;
  logic mod_gate;
  logic sleeping;
  logic env_high;
  int fail_count;
  int check_count;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  rtsq_sequencer #(.SLEEP_CYC(SLP), .HALF_CYC(HALF)) dut (
    .clk(clk),
    .rst(rst),
    .code_word(code_word),
    .mod_gate(mod_gate),
    .sleeping(sleeping)
  );

  rtsq_reader_model reader (
    .mod_gate(mod_gate),
    .env_high(env_high)
  );

  task automatic check(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  task automatic complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // reset for 8 cycles, then stop just after the first half begins
  task automatic apply_reset(input logic [FRAME_BITS-1:0] word);
    @(posedge clk);
    rst <= 1'b1;
    code_word <= word;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : apply_reset

  // every cycle of each bit: inverse half first, then the bit itself
  task automatic send_bits(input logic [FRAME_BITS-1:0] word,
                           input int nbits);
    logic b;
    logic exp;
    for (int i = 0; i < nbits; i++) begin
      b = word[i];
      for (int c = 0; c < BIT_CYC; c++) begin
        exp = (c < HALF) ? ~b : b;
        check("envelope", exp, env_high);
        check("sleep during frame", 1'b0, sleeping);
        @(posedge clk);
        #1;
      end
    end
  endtask : send_bits

  // sleep length and cloaking, new word loaded while asleep
  task automatic sleep_phase(input logic [FRAME_BITS-1:0] next);
    for (int c = 0; c < SLP; c++) begin
      check("sleeping", 1'b1, sleeping);
      check("cloaked in sleep", 1'b1, env_high);
      @(posedge clk);
      if (c == 0)
        code_word <= next;
      #1;
    end
    // two load cycles: buffer refill, then first pop
    for (int c = 0; c < 2; c++) begin
      check("awake after sleep", 1'b0, sleeping);
      check("cloaked at wake", 1'b1, env_high);
      @(posedge clk);
      #1;
    end
  endtask : sleep_phase

  initial begin
    rst = 1'b1;
    code_word = PAT_A;
    fail_count = 0;
    check_count = 0;
    apply_reset(PAT_A);
    send_bits(PAT_A, FRAME_BITS);
    sleep_phase(PAT_B);
    // second frame must restart at bit zero of the new word
    send_bits(PAT_B, 8);
    // reset in mid-frame restarts from bit zero
    apply_reset(PAT_A);
    send_bits(PAT_A, 8);
    complete_run();
  end
endmodule : rtsq_sequencer_tb_top
